// ---- include/dsps_pkg.sv ----
// Shared constants and carriers of the drive status and position scaling block.
// Assumes one 10 MHz clock and a parameter port that uses fieldbus parameter addresses.
package dsps_pkg;
	// Parameter addresses
	localparam logic [15:0] DSPS_ADDR_DENOM = 16'h060E;
	localparam logic [15:0] DSPS_ADDR_NUM = 16'h0610;
	localparam logic [15:0] DSPS_ADDR_ACTION = 16'h1C08;
	localparam logic [15:0] DSPS_ADDR_STOPF = 16'h1C0A;
	// Reset values
	localparam logic [31:0] DSPS_DENOM_RST = 32'h0000_4000;
	localparam logic [31:0] DSPS_NUM_RST = 32'h0000_0001;
	localparam logic [15:0] DSPS_STOPF_RST = 16'h0000;
	// Action word bit positions
	localparam int DSPS_BIT_WARN = 0;
	localparam int DSPS_BIT_ERRC1 = 1;
	localparam int DSPS_BIT_STILL = 6;
	localparam int DSPS_BIT_CW = 7;
	localparam int DSPS_BIT_CCW = 8;
	localparam int DSPS_BIT_IDLE = 11;
	localparam int DSPS_BIT_DECEL = 12;
	localparam int DSPS_BIT_ACCEL = 13;
	localparam int DSPS_BIT_CONST = 14;
	localparam logic [15:0] DSPS_RSVD_MASK = 16'h8620;
	// Standstill threshold in 1/min and internal resolution per revolution
	localparam logic signed [15:0] DSPS_STILL_RPM = 16'sh0009;
	localparam int DSPS_RES_SHIFT = 17;
	localparam logic [31:0] DSPS_POS_MAX = 32'h7FFF_FFFF;

	typedef enum logic [1:0] {
		DSPS_PG_IDLE = 2'b00,
		DSPS_PG_DECEL = 2'b01,
		DSPS_PG_ACCEL = 2'b10,
		DSPS_PG_CONST = 2'b11
	} dsps_phase_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] data;
	} dsps_req_t;

	typedef struct packed {
		logic warning;
		logic [3:0] err_class;
		logic signed [15:0] speed_rpm;
		dsps_phase_t phase;
	} dsps_drive_t;
endpackage : dsps_pkg

// ---- src/dsps_div.sv ----
// Sequential restoring divider for unsigned operands, one quotient bit per clock.
// Assumes the caller holds the divisor nonzero and starts only while not busy.
`timescale 1ns/10ps
`default_nettype none
module dsps_div #(
	parameter int DW = 80,
	parameter int VW = 32
) (
	input wire logic clk_in, // Clock
	input wire logic rst_n_in, // Synchronised reset, active low
	input wire logic start_in, // Start pulse
	input wire logic [DW-1:0] dividend_in, // Dividend
	input wire logic [VW-1:0] divisor_in, // Divisor
	output logic busy_out, // Division running
	output logic done_out, // One-cycle pulse, quotient valid
	output logic [DW-1:0] quot_out // Quotient, rounded toward zero
);
	logic [DW-1:0] shreg;
	logic [VW:0] rem;
	logic [VW-1:0] dvs;
	logic [$clog2(DW+1)-1:0] cnt;
	logic [VW:0] trial;

	always_comb begin
		trial = {rem[VW-1:0], shreg[DW-1]} - {1'b0, dvs};
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shreg <= '0;
			rem <= '0;
			dvs <= '0;
			cnt <= '0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
			quot_out <= '0;
		end else begin
			done_out <= 1'b0;
			if (start_in && !busy_out) begin
				shreg <= dividend_in;
				rem <= '0;
				dvs <= divisor_in;
				cnt <= ($clog2(DW+1))'(DW);
				busy_out <= 1'b1;
			end else if (busy_out) begin
				if (!trial[VW]) begin
					rem <= trial;
				end else begin
					rem <= {rem[VW-1:0], shreg[DW-1]};
				end
				shreg <= {shreg[DW-2:0], ~trial[VW]};
				cnt <= cnt - 1'b1;
				if (cnt == 1) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
					quot_out <= {shreg[DW-2:0], ~trial[VW]};
				end
			end
		end
	end
endmodule : dsps_div
`default_nettype wire

// ---- src/dsps_top.sv ----
// Drive status word, last stop fault, phase fault monitor and position scaling.
// Assumes a parameter port driven by the fieldbus front end, all inputs synchronous.
// What this block does
// - Action word bit 0 shows warning, bits 1 to 4 error classes 1 to 4.
// - Bit 6 set while speed magnitude is below 9 per minute.
// - Bit 7 set while turning clockwise, bit 8 while counter-clockwise.
// - Bits 11 to 14 show idle, decelerating, accelerating, constant speed phase.
// - Read-only 16-bit register holds error number of latest stopping fault.
// - While power stage enabled, every phase is checked for ground and short faults.
// - The DC bus is not monitored for ground faults, only motor phases.
// - Positions convert both ways; stored positions stay in user units.
// - Only a numerator write activates a new scale; host writes denominator first.
// - Default scale is 16384 user units per motor revolution.
// - Internal resolution is 131072 positions per revolution.
// - Small scales limit the working range; leaving it raises an error.
// - Scale changes accepted only while power stage is disabled.
// - Stored user values convert to internal units when power stage enables.
// - User limit values may shrink from the internal factor computation.
`timescale 1ns/10ps
`default_nettype none
module dsps_top
	import dsps_pkg::*;
#(
	parameter int PHASES = 2
) (
	input wire logic clk_in, // 10 MHz clock
	input wire logic reset_n_in, // Asynchronous reset, active low
	input wire dsps_req_t req_in, // Parameter read/write request
	output logic [31:0] rdata_out, // Read answer data
	output logic rvalid_out, // Read answer strobe
	output logic wr_refused_out, // Write refused pulse
	input wire dsps_drive_t drive_in, // Drive state feeding the action word
	output logic [15:0] action_out, // Action word
	input wire logic stop_event_in, // Stopping fault occurred
	input wire logic [15:0] stop_code_in, // Its error number
	input wire logic pwr_en_in, // Power stage enabled
	input wire logic [PHASES-1:0] gnd_sense_in, // Ground fault sense per phase
	input wire logic [PHASES-1:0] short_sense_in, // Short circuit sense per phase
	output logic phase_fault_out, // Phase fault detected
	output logic [PHASES-1:0] fault_phases_out, // Phases that faulted
	input wire logic signed [31:0] user_pos_in, // Stored position, user units
	input wire logic to_int_req_in, // Convert user to internal
	output logic signed [31:0] int_pos_out, // Internal position
	output logic int_valid_out, // Internal result pulse
	input wire logic signed [31:0] int_pos_in, // Internal position to convert back
	input wire logic to_user_req_in, // Convert internal to user
	output logic signed [31:0] user_pos_out, // User position
	output logic user_valid_out, // User result pulse
	output logic [31:0] user_limit_out, // Largest reachable user value
	output logic range_err_out // Working range exceeded, sticky until power off
);
	localparam int FW = 32 + 31 + DSPS_RES_SHIFT;
	localparam int RW = 32 + 31;

	logic rst_s1, rst_n;
	logic [31:0] denom, num, act_denom, act_num;
	logic [15:0] stopf;
	logic pwr_q;
	logic fwd_start, fwd_busy, fwd_done, fwd_neg;
	logic [FW-1:0] fwd_q, fwd_dvd;
	logic rev_start, rev_busy, rev_done, rev_neg, rev_lim, lim_pend;
	logic [RW-1:0] rev_q;
	logic [31:0] fwd_mag, rev_mag;
	logic wr_ok;

	function automatic logic [3:0] dsps_phase_dec(input dsps_phase_t p);
		logic [3:0] r;
		r = 4'h0;
		unique case (p)
			DSPS_PG_IDLE: r[0] = 1'b1;
			DSPS_PG_DECEL: r[1] = 1'b1;
			DSPS_PG_ACCEL: r[2] = 1'b1;
			DSPS_PG_CONST: r[3] = 1'b1;
		endcase
		return r;
	endfunction : dsps_phase_dec

	function automatic logic [31:0] dsps_abs(input logic signed [31:0] v);
		return v[31] ? 32'(-v) : 32'(v);
	endfunction : dsps_abs

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Action word; reserved bits never set
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			action_out <= 16'h0000;
		end else begin
			action_out <= 16'h0000;
			action_out[DSPS_BIT_WARN] <= drive_in.warning;
			action_out[DSPS_BIT_ERRC1 +: 4] <= drive_in.err_class;
			action_out[DSPS_BIT_STILL] <= (drive_in.speed_rpm < DSPS_STILL_RPM) &&
				(drive_in.speed_rpm > -DSPS_STILL_RPM);
			action_out[DSPS_BIT_CW] <= drive_in.speed_rpm > 16'sh0000;
			action_out[DSPS_BIT_CCW] <= drive_in.speed_rpm < 16'sh0000;
			action_out[DSPS_BIT_IDLE +: 4] <= dsps_phase_dec(drive_in.phase);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			stopf <= DSPS_STOPF_RST;
		end else if (stop_event_in) begin
			stopf <= stop_code_in;
		end
	end

	// Phase monitor; only motor phases have sense inputs, the DC bus has none
	genvar g;
	generate
		for (g = 0; g < PHASES; g++) begin : g_phase
			always_ff @(posedge clk_in or negedge rst_n) begin
				if (!rst_n) begin
					fault_phases_out[g] <= 1'b0;
				end else if (pwr_en_in && (gnd_sense_in[g] || short_sense_in[g])) begin
					fault_phases_out[g] <= 1'b1;
				end else if (!pwr_en_in) begin
					fault_phases_out[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			phase_fault_out <= 1'b0;
		end else begin
			phase_fault_out <= pwr_en_in && (|(gnd_sense_in | short_sense_in)) ||
				(pwr_en_in && |fault_phases_out);
		end
	end

	// Zero or negative scale values would break the divider; they are refused
	always_comb begin
		wr_ok = !pwr_en_in && !req_in.data[31] && (req_in.data != 32'h0);
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			denom <= DSPS_DENOM_RST;
			num <= DSPS_NUM_RST;
			act_denom <= DSPS_DENOM_RST;
			act_num <= DSPS_NUM_RST;
			wr_refused_out <= 1'b0;
		end else begin
			wr_refused_out <= 1'b0;
			if (req_in.wr) begin
				if (req_in.addr == DSPS_ADDR_DENOM && wr_ok) begin
					denom <= req_in.data;
				end else if (req_in.addr == DSPS_ADDR_NUM && wr_ok) begin
					num <= req_in.data;
					act_num <= req_in.data;
					act_denom <= denom;
				end else begin
					wr_refused_out <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_out <= 32'h0000_0000;
			rvalid_out <= 1'b0;
		end else begin
			rvalid_out <= req_in.rd;
			unique case (req_in.addr)
				DSPS_ADDR_DENOM: rdata_out <= denom;
				DSPS_ADDR_NUM: rdata_out <= num;
				DSPS_ADDR_ACTION: rdata_out <= {16'h0000, action_out};
				DSPS_ADDR_STOPF: rdata_out <= {16'h0000, stopf};
				default: rdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// Forward: |user| * num shifted by resolution, divided by denom
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q <= 1'b0;
			fwd_neg <= 1'b0;
		end else begin
			pwr_q <= pwr_en_in;
			if (fwd_start && !fwd_busy) begin
				fwd_neg <= user_pos_in[31];
			end
		end
	end

	always_comb begin
		fwd_start = to_int_req_in || (pwr_en_in && !pwr_q);
		fwd_mag = dsps_abs(user_pos_in);
		// A 32 by 31 bit product always fits in 63 bits
		fwd_dvd = {63'(64'(fwd_mag) * 64'(act_num[30:0])), {DSPS_RES_SHIFT{1'b0}}};
	end

	dsps_div #(.DW(FW), .VW(32)) u_fwd (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.start_in(fwd_start),
		.dividend_in(fwd_dvd),
		.divisor_in(act_denom),
		.busy_out(fwd_busy),
		.done_out(fwd_done),
		.quot_out(fwd_q)
	);

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			int_pos_out <= 32'sh0000_0000;
			int_valid_out <= 1'b0;
			range_err_out <= 1'b0;
		end else begin
			int_valid_out <= fwd_done;
			if (fwd_done) begin
				int_pos_out <= fwd_neg ? -$signed(fwd_q[31:0]) : $signed(fwd_q[31:0]);
			end
			if ((fwd_done && fwd_q > FW'(DSPS_POS_MAX)) ||
				(rev_done && !rev_lim && rev_q > RW'(DSPS_POS_MAX))) begin
				range_err_out <= 1'b1;
			end else if (!pwr_en_in) begin
				range_err_out <= 1'b0;
			end
		end
	end

	// Reverse: limit computation after a new scale has priority over requests
	always_comb begin
		rev_start = !rev_busy && (lim_pend || to_user_req_in);
		rev_mag = lim_pend ? DSPS_POS_MAX : dsps_abs(int_pos_in);
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			lim_pend <= 1'b1;
			rev_lim <= 1'b0;
			rev_neg <= 1'b0;
		end else begin
			if (req_in.wr && req_in.addr == DSPS_ADDR_NUM && wr_ok) begin
				lim_pend <= 1'b1;
			end else if (rev_start) begin
				lim_pend <= 1'b0;
			end
			if (rev_start) begin
				rev_lim <= lim_pend;
				rev_neg <= !lim_pend && int_pos_in[31];
			end
		end
	end

	dsps_div #(.DW(RW), .VW(48)) u_rev (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.start_in(rev_start),
		.dividend_in(63'(64'(rev_mag) * 64'(act_denom[30:0]))),
		.divisor_in({act_num[30:0], {DSPS_RES_SHIFT{1'b0}}}),
		.busy_out(rev_busy),
		.done_out(rev_done),
		.quot_out(rev_q)
	);

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			user_pos_out <= 32'sh0000_0000;
			user_valid_out <= 1'b0;
			user_limit_out <= 32'h0000_0000;
		end else begin
			user_valid_out <= rev_done && !rev_lim;
			if (rev_done && rev_lim) begin
				user_limit_out <= (rev_q > RW'(DSPS_POS_MAX)) ? DSPS_POS_MAX :
					rev_q[31:0];
			end else if (rev_done) begin
				user_pos_out <= rev_neg ? -$signed(rev_q[31:0]) : $signed(rev_q[31:0]);
			end
		end
	end

	sequence s_num_write;
		req_in.wr && req_in.addr == DSPS_ADDR_NUM && wr_ok;
	endsequence

	sequence s_pwr_rise;
		pwr_en_in && !pwr_q && !fwd_busy;
	endsequence

	a_warn_bit: assert property (@(posedge clk_in) disable iff (!rst_n)
		1'b1 |=> action_out[DSPS_BIT_WARN] == $past(drive_in.warning))
		else $error("warning bit wrong");
	a_still_bit: assert property (@(posedge clk_in) disable iff (!rst_n)
		1'b1 |=> action_out[DSPS_BIT_STILL] ==
		(($past(drive_in.speed_rpm) < DSPS_STILL_RPM) &&
		($past(drive_in.speed_rpm) > -DSPS_STILL_RPM)))
		else $error("standstill bit wrong");
	a_dir_excl: assert property (@(posedge clk_in) disable iff (!rst_n)
		!(action_out[DSPS_BIT_CW] && action_out[DSPS_BIT_CCW]))
		else $error("both directions set");
	a_phase_onehot: assert property (@(posedge clk_in) disable iff (!rst_n)
		$past(rst_n) |-> $onehot(action_out[DSPS_BIT_IDLE +: 4]))
		else $error("phase bits not one-hot");
	a_rsvd_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
		(action_out & DSPS_RSVD_MASK) == 16'h0000)
		else $error("reserved bit set");
	a_stop_latch: assert property (@(posedge clk_in) disable iff (!rst_n)
		stop_event_in |=> stopf == $past(stop_code_in) ##1 stopf == $past(stopf)
		|| $past(stop_event_in))
		else $error("stop fault number not held");
	a_fault_seen: assert property (@(posedge clk_in) disable iff (!rst_n)
		pwr_en_in && |(gnd_sense_in | short_sense_in) |=> phase_fault_out)
		else $error("phase fault missed");
	a_denom_staged: assert property (@(posedge clk_in) disable iff (!rst_n)
		req_in.wr && req_in.addr == DSPS_ADDR_DENOM |=> $stable(act_denom))
		else $error("denominator applied without numerator");
	a_num_apply: assert property (@(posedge clk_in) disable iff (!rst_n)
		s_num_write |=> act_num == $past(req_in.data) && act_denom == $past(denom))
		else $error("numerator write not applied");
	a_scale_locked: assert property (@(posedge clk_in) disable iff (!rst_n)
		pwr_en_in && req_in.wr |=> $stable(act_num) && $stable(denom) && wr_refused_out)
		else $error("scale changed while enabled");
	a_enable_conv: assert property (@(posedge clk_in) disable iff (!rst_n)
		s_pwr_rise |=> fwd_busy ##[80:81] int_valid_out)
		else $error("no conversion on enable");
endmodule : dsps_top
`default_nettype wire

// ---- bench/dsps_host_model.sv ----
// Fieldbus host model: issues parameter reads and writes on the request port.
// Assumes the bench calls its tasks from one process, between falling edges.
`timescale 1ns/10ps
`default_nettype none
module dsps_host_model
	import dsps_pkg::*;
(
	input wire logic clk_in, // Clock
	output var dsps_req_t req_out, // Request to the block
	input wire logic [31:0] rdata_in, // Read data
	input wire logic rvalid_in, // Read strobe
	input wire logic refused_in // Write refused strobe
);
	initial req_out = '0;

	// Refusal pulse may land one or two falling edges after the request
	task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic f);
		@(negedge clk_in);
		req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		f = 1'b0;
		repeat (2) begin
			@(negedge clk_in);
			req_out.wr <= 1'b0;
			req_out.data <= ~d;
			f = f | (refused_in === 1'b1);
		end
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(negedge clk_in);
		req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 32'h0};
		d = 'x;
		repeat (2) begin
			@(negedge clk_in);
			req_out.rd <= 1'b0;
			if (rvalid_in === 1'b1)
				d = rdata_in;
		end
	endtask : rd

	// Only values 1 to 7FFFFFFF are sent, denominator first
	task automatic set_scale(input logic [31:0] den, input logic [31:0] num, output logic f);
		logic f1;
		wr(DSPS_ADDR_DENOM, den, f1);
		wr(DSPS_ADDR_NUM, num, f);
		f = f | f1;
	endtask : set_scale
endmodule : dsps_host_model
`default_nettype wire

// ---- bench/dsps_tb_top.sv ----
// Self-checking bench of the drive status and position scaling block.
// Assumes the host model drives the parameter port; all else is driven here.
`timescale 1ns/10ps
`default_nettype none
module dsps_tb_top
	import dsps_pkg::*;
;
	logic clk, reset_n, rvalid, refused, stop_event, pwr_en, to_int, to_user;
	logic int_valid, user_valid, phase_fault, range_err;
	logic [31:0] rdata, user_limit;
	logic [15:0] action, stop_code;
	logic [1:0] gnd, shrt, fault_phases;
	logic signed [31:0] user_pos, int_pos, ipos, upos;
	dsps_req_t req;
	dsps_drive_t drive;
	int n_errors = 0;
	int checks_done = 0;

	dsps_host_model u_host (.clk_in(clk), .req_out(req), .rdata_in(rdata),
		.rvalid_in(rvalid), .refused_in(refused));

	dsps_top #(.PHASES(2)) u_dut (.clk_in(clk), .reset_n_in(reset_n), .req_in(req),
		.rdata_out(rdata), .rvalid_out(rvalid), .wr_refused_out(refused),
		.drive_in(drive), .action_out(action), .stop_event_in(stop_event),
		.stop_code_in(stop_code), .pwr_en_in(pwr_en), .gnd_sense_in(gnd),
		.short_sense_in(shrt), .phase_fault_out(phase_fault),
		.fault_phases_out(fault_phases), .user_pos_in(user_pos),
		.to_int_req_in(to_int), .int_pos_out(int_pos), .int_valid_out(int_valid),
		.int_pos_in(ipos), .to_user_req_in(to_user), .user_pos_out(upos),
		.user_valid_out(user_valid), .user_limit_out(user_limit),
		.range_err_out(range_err));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// A missing result leaves r unknown, which the compare then flags
	task automatic wait_res(input bit fwd, output logic [31:0] r);
		r = 'x;
		for (int i = 0; i < 200; i++) begin
			@(negedge clk);
			if ((fwd ? int_valid : user_valid) === 1'b1) begin
				r = fwd ? int_pos : upos;
				i = 200;
			end
		end
	endtask : wait_res

	task automatic conv(input bit fwd, input logic signed [31:0] v, output logic [31:0] r);
		@(negedge clk);
		if (fwd)
			user_pos <= v;
		else
			ipos <= v;
		to_int <= fwd;
		to_user <= !fwd;
		@(negedge clk);
		to_int <= 1'b0;
		to_user <= 1'b0;
		wait_res(fwd, r);
	endtask : conv

	task automatic t_defaults;
		logic [31:0] d;
		logic f;
		u_host.rd(DSPS_ADDR_DENOM, d);
		chk("denominator", 32'h0000_4000, d);
		u_host.rd(DSPS_ADDR_NUM, d);
		chk("numerator", 32'h0000_0001, d);
		u_host.rd(16'h0002, d);
		chk("unmapped read", 32'h0, d);
		u_host.wr(16'h0002, 32'h1, f);
		chk("unmapped write", 32'h1, {31'h0, f});
		chk("user limit", 32'h0FFF_FFFF, user_limit);
		$display("done defaults");
	endtask : t_defaults

	task automatic t_action;
		logic signed [15:0] spd [4] = '{16'sh0000, 16'sh0014, 16'shFFEC, 16'sh0005};
		logic [15:0] e;
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			drive <= '{warning: i[0], err_class: 4'h1 << i, speed_rpm: spd[i],
				phase: dsps_phase_t'(i[1:0])};
			e = 16'h0;
			e[0] = i[0];
			e[4:1] = 4'h1 << i;
			e[6] = spd[i] < 16'sh0009 && spd[i] > 16'shFFF7;
			e[7] = spd[i] > 16'sh0000;
			e[8] = spd[i] < 16'sh0000;
			e[11 + i] = 1'b1;
			@(negedge clk);
			chk("action word", {16'h0, e}, {16'h0, action});
			u_host.rd(DSPS_ADDR_ACTION, d);
			chk("action read", {16'h0, e}, d);
		end
		$display("done action");
	endtask : t_action

	task automatic t_stop;
		logic [31:0] d;
		logic f;
		@(negedge clk);
		stop_code <= 16'hA5C3;
		stop_event <= 1'b1;
		@(negedge clk);
		stop_event <= 1'b0;
		stop_code <= 16'h5A3C;
		u_host.rd(DSPS_ADDR_STOPF, d);
		chk("stop fault", 32'h0000_A5C3, d);
		u_host.wr(DSPS_ADDR_STOPF, 32'h1, f);
		chk("stop fault write", 32'h1, {31'h0, f});
		$display("done stop");
	endtask : t_stop

	task automatic t_phase;
		@(negedge clk);
		gnd <= 2'b10;
		repeat (2) @(negedge clk);
		chk("unpowered", 32'h0, {29'h0, phase_fault, fault_phases});
		pwr_en <= 1'b1;
		gnd <= 2'b00;
		shrt <= 2'b01;
		repeat (2) @(negedge clk);
		chk("short", 32'h5, {29'h0, phase_fault, fault_phases});
		shrt <= 2'b00;
		gnd <= 2'b10;
		repeat (2) @(negedge clk);
		chk("ground", 32'h7, {29'h0, phase_fault, fault_phases});
		pwr_en <= 1'b0;
		repeat (2) @(negedge clk);
		chk("disabled", 32'h0, {29'h0, phase_fault, fault_phases});
		gnd <= 2'b00;
		$display("done phase");
	endtask : t_phase

	task automatic t_scale;
		logic [31:0] r;
		logic f;
		repeat (100) @(negedge clk);
		user_pos <= 32'sh0000_0064;
		pwr_en <= 1'b1;
		wait_res(1'b1, r);
		chk("enable convert", 32'h0000_0320, r);
		u_host.wr(DSPS_ADDR_DENOM, 32'h5, f);
		chk("powered write", 32'h1, {31'h0, f});
		@(negedge clk);
		pwr_en <= 1'b0;
		u_host.wr(DSPS_ADDR_DENOM, 32'h0000_0457, f);
		conv(1'b1, 32'sh0000_0384, r);
		chk("denominator only", 32'h0000_1C20, r);
		u_host.rd(DSPS_ADDR_DENOM, r);
		chk("denominator read", 32'h0000_0457, r);
		u_host.wr(DSPS_ADDR_NUM, 32'h3, f);
		chk("numerator write", 32'h0, {31'h0, f});
		repeat (100) @(negedge clk);
		conv(1'b1, 32'sh0000_0384, r);
		chk("to internal", 32'h0004_DC48, r);
		conv(1'b0, 32'sh0004_DC48, r);
		chk("to user", 32'h0000_0383, r);
		conv(1'b1, 32'shFFFF_FC7C, r);
		chk("negative to internal", 32'hFFFB_23B8, r);
		conv(1'b0, 32'shFFFB_23B8, r);
		chk("negative to user", 32'hFFFF_FC7D, r);
		u_host.wr(DSPS_ADDR_NUM, 32'h0, f);
		chk("zero numerator", 32'h1, {31'h0, f});
		u_host.wr(DSPS_ADDR_NUM, 32'h8000_0000, f);
		chk("negative numerator", 32'h1, {31'h0, f});
		u_host.set_scale(32'h1, 32'h7FFF_FFFF, f);
		chk("largest scale", 32'h0, {31'h0, f});
		repeat (100) @(negedge clk);
		chk("small limit", 32'h0, user_limit);
		user_pos <= 32'sh0000_0001;
		pwr_en <= 1'b1;
		wait_res(1'b1, r);
		@(negedge clk);
		chk("range error", 32'h1, {31'h0, range_err});
		pwr_en <= 1'b0;
		repeat (2) @(negedge clk);
		chk("range cleared", 32'h0, {31'h0, range_err});
		$display("done scale");
	endtask : t_scale

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		reset_n = 1'b0;
		drive = '0;
		stop_event = 1'b0;
		stop_code = 16'h0;
		pwr_en = 1'b0;
		gnd = 2'b00;
		shrt = 2'b00;
		user_pos = 32'sh0;
		ipos = 32'sh0;
		to_int = 1'b0;
		to_user = 1'b0;
		repeat (20) @(negedge clk);
		reset_n <= 1'b1;
		// Leaves room for the limit job that follows reset
		repeat (100) @(negedge clk);
		t_defaults();
		t_action();
		t_stop();
		t_phase();
		t_scale();
		final_report();
	end

	// The sequence needs about 1050 cycles
	initial begin
		repeat (10000) @(posedge clk);
		n_errors++;
		final_report();
	end
endmodule : dsps_tb_top
`default_nettype wire
